// ---- design/acs_async_char_serial.sv ----
// Purpose: Asynchronous / isochronous character mode of one serial channel.
// Assumes: Bit timing from a divider of the system clock; pins are synchronised here.
// Notes:   Receive words leave through a 4-word FIFO whose drain side may stall.
//
// Functional notes
// - Oversampled: verify start bit, resync per character, 3-sample majority per bit.
// - Isochronous: bit clock equals data rate, each bit sampled once.
// - Store enabled receive characters LSB first; check length, stops, parity; parity storage optional.
// - Flag framing and parity errors; optionally store error status with character.
// - Receive fill report uses threshold, data format and termination char.
// - Optional time-out event after programmable idle interval since last character.
// - Transmit FIFO data LSB first after transmit-frame command; request more data.
// - Frame: start bit, data bits, optional parity, configured stop bits.
// - After all data sent raise all-sent then hold line at idle one.
// - Break-send forces output low from next bit edge, releases after clear.
// - All-zero character is break: not stored, break event, break-ended on next one.
// - Flow characters compared over length; mask ones are don't-care; masks reset zero.
// - Flow character valid only if framed, matching under mask and parity correct.
// - Recognised flow characters stored when discard bit zero, dropped when one.
// - Recognition raises event; auto flow stops after current char on off, resumes on on.
// - Auto flow off at reset; enabling starts flow-on; disabling forces flow-on.
// - Transmit only while clear-to-send low and flow-on, gating independent.
// - Flow state flag reads 0 in flow-on and 1 in flow-off.
// - Immediate char sent now if idle, else after current char; FIFO untouched.
// - Immediate char sent in flow-off if clear-to-send low; uses line format.
// - Busy flag set from immediate char acceptance until fully sent; software waits.
// - Five to eight data bits, one or two stops, even/odd/mark/space parity.
`timescale 1ns/100ps
`default_nettype none
module acs_async_char_serial (
  input  wire logic            clk,
  input  wire logic            sys_rst,
  input  wire logic            rxdPin,
  output logic                 txdPin,
  input  wire logic            ctsPin_n,
  input  wire logic            oversample16,
  input  wire logic [15:0]     bitDivisor,
  input  wire acs_pkg::acs_fmt_t lineFmt,
  input  wire logic            rxEnable,
  input  wire logic            parity_storage_disable,
  input  wire logic            rx_fifo_data_format,
  input  wire logic [1:0]      rx_fifo_threshold,
  input  wire logic            term_char_detect_en,
  input  wire logic [7:0]      termination_char_value,
  input  wire logic [15:0]     rx_timeout_length,
  input  wire logic            rxTimeoutEn,
  input  wire logic            transmit_frame_cmd,
  input  wire logic [7:0]      txData,
  input  wire logic            txValid,
  output logic                 txReady,
  input  wire logic            send_break_ctrl,
  input  wire logic [7:0]      flowOnChar,
  input  wire logic [7:0]      flowOffChar,
  input  wire logic [7:0]      flow_on_mask,
  input  wire logic [7:0]      flow_off_mask,
  input  wire logic            discard_flow_chars,
  input  wire logic            auto_flow_enable,
  input  wire logic [7:0]      immediate_char,
  input  wire logic            immediateWrite,
  output logic                 immediate_char_busy,
  output logic                 flow_state_flag,
  output acs_pkg::acs_rxw_t    rxWord,
  output logic                 rxWordValid,
  input  wire logic            rxWordReady,
  output logic                 rxFillReport,
  output logic                 framingErrIrq,
  output logic                 parityErrIrq,
  output logic                 rxTimeoutIrq,
  output logic                 tx_pool_ready_irq,
  output logic                 all_sent_irq,
  output logic                 break_detect_irq,
  output logic                 break_ended_irq,
  output logic                 flowOnIrq,
  output logic                 flowOffIrq
);
  import acs_pkg::*;

  function automatic logic parityOf(input logic [7:0] d, input logic [1:0] len, input logic [1:0] mode);
    logic [7:0] m;
    m = 8'hFF >> (3 - len);
    case (mode)
      ACS_PAR_EVEN:  parityOf = ^(d & m);
      ACS_PAR_ODD:   parityOf = ~^(d & m);
      ACS_PAR_SPACE: parityOf = 1'b0;
      default:       parityOf = 1'b1;
    endcase
  endfunction : parityOf

  function automatic logic charMatch(input logic [7:0] d, input logic [7:0] ref_, input logic [7:0] msk,
                                     input logic [1:0] len);
    charMatch = (((d ^ ref_) & ~msk & (8'hFF >> (3 - len))) == 8'h00);
  endfunction : charMatch

  // ==========================================================================
  // Pin synchronisers and sample tick
  // ==========================================================================
  logic rxS1_q, rxS2_q, ctsS1_q, ctsS2_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rxS1_q <= 1'b1;
      rxS2_q <= 1'b1;
      ctsS1_q <= 1'b1;
      ctsS2_q <= 1'b1;
    end else begin
      rxS1_q <= rxdPin;
      rxS2_q <= rxS1_q;
      ctsS1_q <= ctsPin_n;
      ctsS2_q <= ctsS1_q;
    end
  end

  // One tick per sample; 16 ticks per bit when oversampling, one otherwise.
  logic [15:0] divCnt_q;
  logic        tick;
  assign tick = (divCnt_q == 16'h0000);
  always_ff @(posedge clk) begin
    if (sys_rst || tick) divCnt_q <= bitDivisor;
    else divCnt_q <= divCnt_q - 16'h0001;
  end

  logic [3:0] lastTick;
  assign lastTick = oversample16 ? 4'hF : 4'h0;

  // ==========================================================================
  // Receiver
  // ==========================================================================
  acs_rxst_t  rxSt_q;
  logic [3:0] rxPh_q;
  logic [2:0] rxBit_q;
  logic [7:0] rxSh_q;
  logic       rxPar_q;
  logic       rxStop2_q;
  logic [2:0] vote_q;
  logic       sample;
  logic       rxDone;
  logic       rxFrameOk;
  logic       rxParOk;
  logic       rxAllZero;
  acs_rxw_t   rxPush;
  logic       rxPushValid;
  logic       fifoInReady;
  logic       isFlowOn, isFlowOff;

  // Majority of three samples centred on tick 7; single sample in isochronous mode.
  always_comb begin
    if (oversample16) sample = (vote_q[0] & vote_q[1]) | (vote_q[1] & vote_q[2]) | (vote_q[0] & vote_q[2]);
    else sample = rxS2_q;
  end

  logic bitPoint;
  assign bitPoint = tick && (oversample16 ? (rxPh_q == ACS_MID_TICK + 4'h1) : 1'b1);

  always_ff @(posedge clk) begin
    if (sys_rst) vote_q <= 3'b111;
    else if (tick) vote_q <= {vote_q[1:0], rxS2_q};
  end

  logic stopBit;
  assign stopBit = sample;
  always_ff @(posedge clk) begin
    if (sys_rst || !rxEnable) begin
      rxSt_q <= ACS_RX_IDLE;
      rxPh_q <= 4'h0;
      rxBit_q <= 3'h0;
      rxSh_q <= 8'h00;
      rxPar_q <= 1'b0;
      rxStop2_q <= 1'b0;
    end else if (tick) begin
      rxPh_q <= (rxPh_q == lastTick) ? 4'h0 : rxPh_q + 4'h1;
      case (rxSt_q)
        ACS_RX_IDLE: begin
          if (!rxS2_q) begin // Resync on the first low sample while idle.
            rxSt_q <= ACS_RX_START;
            rxPh_q <= 4'h0;
          end
        end
        ACS_RX_START: begin
          if (bitPoint) begin
            rxSt_q <= sample ? ACS_RX_IDLE : ACS_RX_DATA; // False start drops back.
            rxBit_q <= 3'h0;
          end
        end
        ACS_RX_DATA: begin
          if (bitPoint) begin
            rxSh_q[rxBit_q] <= sample; // LSB first.
            rxBit_q <= rxBit_q + 3'h1;
            if (rxBit_q == {1'b0, lineFmt.charLen} + 3'h4) begin
              rxSt_q <= lineFmt.parityEn ? ACS_RX_PARITY : ACS_RX_STOP;
              rxStop2_q <= 1'b0;
            end
          end
        end
        ACS_RX_PARITY: begin
          if (bitPoint) begin
            rxPar_q <= sample;
            rxSt_q <= ACS_RX_STOP;
          end
        end
        ACS_RX_STOP: begin
          if (bitPoint) begin
            if (lineFmt.twoStop && !rxStop2_q && stopBit) rxStop2_q <= 1'b1;
            else rxSt_q <= (rxAllZero && !stopBit) ? ACS_RX_BREAK : ACS_RX_IDLE;
          end
        end
        ACS_RX_BREAK: begin
          if (rxS2_q) rxSt_q <= ACS_RX_IDLE;
        end
        default: rxSt_q <= ACS_RX_IDLE;
      endcase
    end
  end

  logic [7:0] rxMasked;
  assign rxMasked  = rxSh_q & (8'hFF >> (3 - lineFmt.charLen));
  assign rxDone    = tick && bitPoint && (rxSt_q == ACS_RX_STOP) && !(lineFmt.twoStop && !rxStop2_q && stopBit);
  assign rxFrameOk = stopBit;
  assign rxParOk   = !lineFmt.parityEn || (rxPar_q == parityOf(rxSh_q, lineFmt.charLen, lineFmt.parityMode));
  assign rxAllZero = (rxMasked == 8'h00) && (!lineFmt.parityEn || !rxPar_q);
  assign isFlowOn  = rxFrameOk && rxParOk && charMatch(rxSh_q, flowOnChar, flow_on_mask, lineFmt.charLen);
  assign isFlowOff = rxFrameOk && rxParOk && charMatch(rxSh_q, flowOffChar, flow_off_mask, lineFmt.charLen);

  logic breakChar;
  assign breakChar = rxAllZero && !rxFrameOk;

  always_comb begin
    rxPush.data      = rxMasked;
    rxPush.parityBit = (lineFmt.parityEn && !parity_storage_disable) ? rxPar_q : 1'b0;
    rxPush.parityErr = rx_fifo_data_format ? !rxParOk : 1'b0;
    rxPush.frameErr  = rx_fifo_data_format ? !rxFrameOk : 1'b0;
    rxPushValid      = rxDone && !breakChar && !(discard_flow_chars && (isFlowOn || isFlowOff));
  end

  // Characters arriving while the FIFO is full are lost; the far side must pace.
  acs_fifo #(
    .WIDTH (ACS_RXW_WIDTH),
    .DEPTH (ACS_FIFO_DEPTH)
  ) uRxFifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .inData    (rxPush),
    .inValid   (rxPushValid),
    .inReady   (fifoInReady),
    .outData   (rxWord),
    .outValid  (rxWordValid),
    .outReady  (rxWordReady),
    .fifoEmpty ()
  );

  // ==========================================================================
  // Receive events, fill report and time-out
  // ==========================================================================
  logic [2:0]  rxCount_q;
  logic [15:0] toCnt_q;
  logic        toArmed_q;
  logic        termSeen_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      framingErrIrq <= 1'b0;
      parityErrIrq <= 1'b0;
      break_detect_irq <= 1'b0;
      break_ended_irq <= 1'b0;
      flowOnIrq <= 1'b0;
      flowOffIrq <= 1'b0;
    end else begin
      framingErrIrq <= rxDone && !rxFrameOk && !breakChar;
      parityErrIrq <= rxDone && !rxParOk && !breakChar;
      break_detect_irq <= rxDone && breakChar;
      break_ended_irq <= tick && (rxSt_q == ACS_RX_BREAK) && rxS2_q;
      flowOnIrq <= rxDone && isFlowOn;
      flowOffIrq <= rxDone && isFlowOff;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rxCount_q <= 3'h0;
      termSeen_q <= 1'b0;
      rxFillReport <= 1'b0;
    end else begin
      rxCount_q <= rxCount_q + 3'(rxPushValid && fifoInReady) - 3'(rxWordValid && rxWordReady);
      if (rxPushValid && fifoInReady && term_char_detect_en && rxMasked == termination_char_value)
        termSeen_q <= 1'b1;
      else if (rxCount_q == 3'h0) termSeen_q <= 1'b0;
      // Status bytes double the space each character takes.
      rxFillReport <= (({1'b0, rxCount_q} << rx_fifo_data_format) > {2'b00, rx_fifo_threshold}) || termSeen_q;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      toCnt_q <= 16'h0000;
      toArmed_q <= 1'b0;
      rxTimeoutIrq <= 1'b0;
    end else begin
      rxTimeoutIrq <= 1'b0;
      if (rxDone) begin
        toCnt_q <= rx_timeout_length;
        toArmed_q <= rxTimeoutEn;
      end else if (toArmed_q && tick && rxSt_q == ACS_RX_IDLE) begin
        if (toCnt_q == 16'h0000) begin
          rxTimeoutIrq <= 1'b1;
          toArmed_q <= 1'b0;
        end else toCnt_q <= toCnt_q - 16'h0001;
      end
    end
  end

  // ==========================================================================
  // Flow state
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (sys_rst || !auto_flow_enable) flow_state_flag <= 1'b0;
    else if (rxDone && isFlowOff) flow_state_flag <= 1'b1;
    else if (rxDone && isFlowOn) flow_state_flag <= 1'b0;
  end

  // ==========================================================================
  // Transmitter
  // ==========================================================================
  acs_txst_t  txSt_q;
  logic [3:0] txPh_q;
  logic [2:0] txBit_q;
  logic [7:0] txSh_q;
  logic       txStop2_q;
  logic       txLine_q;
  logic       txRun_q;
  logic       icPend_q;
  logic       icSending_q;
  logic       brk_q;
  logic       bitEdge;
  logic       ctsOk;
  logic       txLoadFifo;
  logic       txLoadIc;

  assign bitEdge    = tick && (txPh_q == lastTick);
  assign ctsOk      = !ctsS2_q;
  assign txLoadIc   = bitEdge && txSt_q == ACS_TX_IDLE && icPend_q && ctsOk;
  assign txLoadFifo = bitEdge && txSt_q == ACS_TX_IDLE && !icPend_q && txRun_q && txValid && ctsOk
                      && !flow_state_flag;
  assign txReady    = txLoadFifo;

  always_ff @(posedge clk) begin
    if (sys_rst) txPh_q <= 4'h0;
    else if (tick) txPh_q <= (txPh_q == lastTick) ? 4'h0 : txPh_q + 4'h1;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      txRun_q <= 1'b0;
      icPend_q <= 1'b0;
      immediate_char_busy <= 1'b0;
    end else begin
      if (transmit_frame_cmd) txRun_q <= 1'b1;
      else if (bitEdge && txSt_q == ACS_TX_IDLE && !txValid && !icPend_q) txRun_q <= 1'b0;
      if (immediateWrite && !immediate_char_busy) begin
        icPend_q <= 1'b1;
        immediate_char_busy <= 1'b1;
      end else if (txLoadIc) icPend_q <= 1'b0;
      if (icSending_q && bitEdge && txSt_q == ACS_TX_STOP && !(lineFmt.twoStop && !txStop2_q))
        immediate_char_busy <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      txSt_q <= ACS_TX_IDLE;
      txBit_q <= 3'h0;
      txSh_q <= 8'h00;
      txStop2_q <= 1'b0;
      txLine_q <= 1'b1;
      icSending_q <= 1'b0;
      tx_pool_ready_irq <= 1'b0;
      all_sent_irq <= 1'b0;
    end else begin
      tx_pool_ready_irq <= txLoadFifo;
      all_sent_irq <= 1'b0;
      if (bitEdge) begin
        case (txSt_q)
          ACS_TX_IDLE: begin
            txLine_q <= 1'b1;
            if (txLoadIc || txLoadFifo) begin
              txSh_q <= txLoadIc ? immediate_char : txData;
              icSending_q <= txLoadIc;
              txSt_q <= ACS_TX_START;
              txLine_q <= 1'b0;
            end
          end
          ACS_TX_START: begin
            txSt_q <= ACS_TX_DATA;
            txBit_q <= 3'h1;
            txLine_q <= txSh_q[0];
          end
          ACS_TX_DATA: begin
            if (txBit_q == {1'b0, lineFmt.charLen} + 3'h5) begin
              txSt_q <= lineFmt.parityEn ? ACS_TX_PARITY : ACS_TX_STOP;
              txLine_q <= lineFmt.parityEn ? parityOf(txSh_q, lineFmt.charLen, lineFmt.parityMode) : 1'b1;
              txStop2_q <= 1'b0;
            end else begin
              txLine_q <= txSh_q[txBit_q];
              txBit_q <= txBit_q + 3'h1;
            end
          end
          ACS_TX_PARITY: begin
            txSt_q <= ACS_TX_STOP;
            txLine_q <= 1'b1;
          end
          ACS_TX_STOP: begin
            if (lineFmt.twoStop && !txStop2_q) txStop2_q <= 1'b1;
            else begin
              txSt_q <= ACS_TX_IDLE;
              txLine_q <= 1'b1;
              icSending_q <= 1'b0;
              all_sent_irq <= !txValid && !icPend_q;
            end
          end
          default: txSt_q <= ACS_TX_IDLE;
        endcase
      end
    end
  end

  // Break takes effect and releases only on bit edges.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      brk_q <= 1'b0;
      txdPin <= 1'b1;
    end else begin
      if (bitEdge) brk_q <= send_break_ctrl;
      txdPin <= brk_q ? 1'b0 : txLine_q;
    end
  end
endmodule : acs_async_char_serial
`default_nettype wire

// ---- design/acs_pkg.sv ----
// Purpose: Shared constants and carrier types for the async character serial block.
// Assumes: One clock at 125 MHz, synchronous active-high reset.
// Notes:   Bit timing comes from a programmable divider in system clock cycles.
package acs_pkg;

  // ==========================================================================
  // Character format
  // ==========================================================================
  localparam logic [1:0] ACS_PAR_EVEN  = 2'h0;
  localparam logic [1:0] ACS_PAR_ODD   = 2'h1;
  localparam logic [1:0] ACS_PAR_SPACE = 2'h2;
  localparam logic [1:0] ACS_PAR_MARK  = 2'h3;
  localparam int         ACS_OVERSAMPLE = 16;
  localparam logic [3:0] ACS_MID_TICK   = 4'h7;
  localparam logic [7:0] ACS_MASK_RST   = 8'h00;
  localparam int         ACS_FIFO_DEPTH = 4;
  localparam int         ACS_RXW_WIDTH  = 11;

  // Line format shared by both directions.
  typedef struct packed {
    logic [1:0] charLen;    // 0..3 means 5..8 data bits.
    logic       parityEn;
    logic [1:0] parityMode;
    logic       twoStop;
  } acs_fmt_t;

  // One receive FIFO word: status bits above the data byte.
  typedef struct packed {
    logic       frameErr;
    logic       parityErr;
    logic       parityBit;
    logic [7:0] data;
  } acs_rxw_t;

  typedef enum logic [2:0] {
    ACS_TX_IDLE   = 3'b000,
    ACS_TX_START  = 3'b001,
    ACS_TX_DATA   = 3'b010,
    ACS_TX_PARITY = 3'b011,
    ACS_TX_STOP   = 3'b100
  } acs_txst_t;

  typedef enum logic [2:0] {
    ACS_RX_IDLE   = 3'b000,
    ACS_RX_START  = 3'b001,
    ACS_RX_DATA   = 3'b010,
    ACS_RX_PARITY = 3'b011,
    ACS_RX_STOP   = 3'b100,
    ACS_RX_BREAK  = 3'b101
  } acs_rxst_t;

endpackage : acs_pkg

// ---- design/acs_fifo.sv ----
// Purpose: Small synchronous FIFO with valid/ready on both sides.
// Assumes: Single clock, synchronous active-high reset.
// Notes:   Full and empty are exact; no write when full, no read when empty.
`timescale 1ns/100ps
`default_nettype none
module acs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output var  logic             inReady,
  output var  logic [WIDTH-1:0] outData,
  output var  logic             outValid,
  input  wire logic             outReady,
  output var  logic             fifoEmpty
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [AW:0]      count_q;
  logic             doWr;
  logic             doRd;

  assign inReady   = (count_q != (AW+1)'(DEPTH));
  assign outValid  = (count_q != '0);
  assign fifoEmpty = (count_q == '0);
  assign outData   = mem[rdPtr_q];
  assign doWr      = inValid && inReady;
  assign doRd      = outValid && outReady;

  always_ff @(posedge clk) begin
    if (doWr) begin
      mem[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (doWr) begin
        wrPtr_q <= (wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
      end
      if (doRd) begin
        rdPtr_q <= (rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(doWr) - (AW+1)'(doRd);
    end
  end
endmodule : acs_fifo
`default_nettype wire

// ---- tb/acs_checker.sv ----
// Purpose: Port-level checks on the character serial block.
// Assumes: bitDivisor is 1 with 16x sampling, so one bit time is 32 clocks.
// Notes:   Bounds add slack for the pin synchronisers.
`timescale 1ns/100ps
`default_nettype none
module acs_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic txdPin,
  input wire logic ctsPin_n,
  input wire logic txValid,
  input wire logic txReady,
  input wire logic send_break_ctrl,
  input wire logic auto_flow_enable,
  input wire logic immediateWrite,
  input wire logic immediate_char_busy,
  input wire logic flow_state_flag,
  input wire logic tx_pool_ready_irq,
  input wire logic all_sent_irq,
  input wire logic flowOffIrq
);
  localparam int BIT_MAX = 40;
  localparam int CHAR_MAX = 400;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ==========
  // Transmit
  sequence takeS;
    txValid && txReady;
  endsequence
  chk_pool_after_take: assert property (takeS |=> tx_pool_ready_irq)
    else $error("no pool ready after take");
  chk_start_after_take: assert property (takeS |-> ##2 !txdPin)
    else $error("no start bit after take");
  chk_idle_in_reset: assert property (disable iff (1'b0) sys_rst |=> txdPin)
    else $error("line not idle in reset");
  chk_idle_after_sent: assert property (all_sent_irq |=> txdPin [*8])
    else $error("line not idle after all sent");
  chk_break_forces_low: assert property ($rose(send_break_ctrl) |-> ##[1:BIT_MAX] !txdPin)
    else $error("break not driven");
  chk_break_stays_low: assert property (send_break_ctrl && $past(send_break_ctrl, 40) |-> !txdPin)
    else $error("break released early");
  // ==========
  // Flow control
  chk_cts_blocks_take: assert property (ctsPin_n [*4] |-> !txReady)
    else $error("take while cts high");
  chk_flowoff_blocks_take: assert property (flow_state_flag |-> !txReady)
    else $error("take in flow off");
  chk_autoflow_off_state: assert property (!auto_flow_enable [*3] |-> !flow_state_flag)
    else $error("flow off without auto flow");
  chk_flowoff_sets_flag: assert property (flowOffIrq && auto_flow_enable |-> ##[0:CHAR_MAX] flow_state_flag)
    else $error("flow off char ignored");
  chk_busy_on_write: assert property (immediateWrite && !immediate_char_busy |=> immediate_char_busy [*8])
    else $error("busy not held after write");
endmodule : acs_checker
bind acs_async_char_serial acs_checker u_chk (.clk, .sys_rst, .txdPin, .ctsPin_n, .txValid, .txReady,
  .send_break_ctrl, .auto_flow_enable, .immediateWrite, .immediate_char_busy, .flow_state_flag,
  .tx_pool_ready_irq, .flowOffIrq, .all_sent_irq);
`default_nettype wire

// ---- tb/acs_remote_station.sv ----
// Purpose: Remote serial station that sends frames and decodes the block's output.
// Assumes: Line idles at one between frames.
// Notes:   Decoded word is stop, parity and data bits of one frame.
`timescale 1ns/100ps
`default_nettype none
module acs_remote_station #(
  parameter int BIT_CLKS = 32
) (
  input  wire logic       clk,
  input  wire logic       txd,
  output var  logic       rxd,
  output var  logic [9:0] rcvChar,
  output var  logic       rcvValid
);
  initial begin
    rxd = 1'b1;
    rcvValid = 1'b0;
    rcvChar = 10'h000;
  end
  // Bit 0 of the frame goes first; one idle bit follows the frame.
  task automatic send(input logic [10:0] f);
    for (int i = 0; i < 12; i++) begin
      @(negedge clk) rxd = (i < 11) ? f[i] : 1'b1;
      repeat (BIT_CLKS - 1) @(negedge clk);
    end
  endtask : send
  always begin
    @(negedge txd);
    repeat (BIT_CLKS / 2) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      repeat (BIT_CLKS) @(posedge clk);
      rcvChar[i] <= txd;
    end
    @(posedge clk) rcvValid <= 1'b1;
    @(posedge clk) rcvValid <= 1'b0;
  end
endmodule : acs_remote_station
`default_nettype wire

// ---- tb/acs_async_char_serial_tb.sv ----
// Purpose: Self-checking bench for the character serial block.
// Assumes: 8 data bits, even parity, one stop, 32 clocks per bit.
// Notes:   Expected words wait in queues until the watcher pops them.
`timescale 1ns/100ps
`default_nettype none
module acs_async_char_serial_tb;
  import acs_pkg::*;
  localparam int BIT = 32;
  logic clk, sys_rst, rxdPin, txdPin, ctsPin_n, oversample16, rxEnable, parity_storage_disable;
  logic rx_fifo_data_format, term_char_detect_en, rxTimeoutEn, transmit_frame_cmd, txValid, txReady;
  logic send_break_ctrl, discard_flow_chars, auto_flow_enable, immediateWrite, immediate_char_busy;
  logic flow_state_flag, rxWordValid, rxWordReady, rxFillReport, framingErrIrq, parityErrIrq, rxTimeoutIrq;
  logic tx_pool_ready_irq, all_sent_irq, break_detect_irq, break_ended_irq, flowOnIrq, flowOffIrq, rcvValid;
  logic [15:0] bitDivisor, rx_timeout_length;
  logic [1:0]  rx_fifo_threshold;
  logic [7:0]  termination_char_value, txData, flowOnChar, flowOffChar, flow_on_mask, flow_off_mask;
  logic [7:0]  immediate_char, d;
  logic [9:0]  rcvChar;
  acs_fmt_t    lineFmt;
  acs_rxw_t    rxWord;
  logic [31:0] seed = 32'h2A6A364F;
  logic [31:0] rdyS = 32'h2A6A364F;
  logic [10:0] rxQ[$];
  logic [9:0]  txQ[$];
  int          fail_count = 0;
  int          cmp_count = 0;
  int          evCnt = 0;
  acs_async_char_serial DUT (.*);
  acs_remote_station #(.BIT_CLKS(BIT)) remote (.clk, .txd(txdPin), .rxd(rxdPin), .rcvChar, .rcvValid);
  // ==========
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic check(input logic [10:0] seen, input logic [10:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  task automatic sendTx(input logic [7:0] v);
    @(negedge clk) txValid = 1'b1;
    txData = v;
    while (txReady !== 1'b1) @(negedge clk);
    txQ.push_back({1'b1, ^v, v});
    @(negedge clk) txValid = 1'b0;
  endtask : sendTx
  // ==========
  // Clock, watchdog, watchers
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    give_verdict();
  end
  always @(negedge clk) begin
    rdyS = xs(rdyS);
    rxWordReady = rdyS[1:0] != 2'b00;
  end
  always @(posedge clk) evCnt <= evCnt + break_detect_irq + break_ended_irq + parityErrIrq + framingErrIrq;
  always @(posedge clk) begin
    if ((rxWordValid && rxWordReady) === 1'b1) check(rxWord, rxQ.pop_front(), "rx word");
    if (rcvValid === 1'b1) check({1'b0, rcvChar}, {1'b0, txQ.pop_front()}, "tx char");
  end
  // ==========
  // Main sequence
  initial begin
    {sys_rst, oversample16, rxEnable, rx_fifo_data_format, term_char_detect_en, rxTimeoutEn} = 6'h3F;
    {ctsPin_n, parity_storage_disable, transmit_frame_cmd, txValid, send_break_ctrl} = 5'h00;
    {discard_flow_chars, auto_flow_enable, immediateWrite} = 3'h0;
    {bitDivisor, rx_timeout_length, rx_fifo_threshold} = {16'h0001, 16'h0040, 2'h1};
    {termination_char_value, txData, flowOnChar, flowOffChar} = 32'h0D001113;
    {flow_on_mask, flow_off_mask, immediate_char} = 24'h0000A5;
    lineFmt = '{2'h3, 1'b1, ACS_PAR_EVEN, 1'b0};
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    // The last random character carries a wrong parity bit.
    for (int i = 0; i < 7; i++) begin
      seed = xs(seed);
      d = seed[7:0];
      rxQ.push_back({1'b0, i == 6, ^d ^ (i == 6), d});
      remote.send({1'b1, ^d ^ (i == 6), d, 1'b0});
    end
    remote.send(11'h000);
    check(11'(evCnt), 11'h003, "break events");
    auto_flow_enable = 1'b1;
    discard_flow_chars = 1'b1;
    remote.send({2'b11, 8'h13, 1'b0});
    check(flow_state_flag, 11'h001, "flow flag");
    fork
      begin
        sendTx(8'h3C);
        sendTx(seed[15:8]);
      end
    join_none
    transmit_frame_cmd = 1'b1;
    @(negedge clk) transmit_frame_cmd = 1'b0;
    repeat (BIT * 12) @(negedge clk);
    // The immediate character must overtake the blocked FIFO data.
    txQ.push_back({2'b10, 8'hA5});
    immediateWrite = 1'b1;
    @(negedge clk) immediateWrite = 1'b0;
    check(immediate_char_busy, 11'h001, "busy");
    for (int k = 0; k < 900 && immediate_char_busy; k++) @(negedge clk);
    ctsPin_n = 1'b1;
    remote.send({2'b10, 8'h11, 1'b0});
    check(flow_state_flag, 11'h000, "flow flag");
    repeat (BIT * 4) @(negedge clk);
    ctsPin_n = 1'b0;
    repeat (BIT * 26) @(negedge clk);
    for (int k = 0; k < 2000 && txQ.size() > 0; k++) @(negedge clk);
    repeat (BIT * 2) @(negedge clk);
    txQ.push_back(10'h000);
    send_break_ctrl = 1'b1;
    repeat (BIT * 12) @(negedge clk);
    send_break_ctrl = 1'b0;
    repeat (BIT * 3) @(negedge clk);
    check(11'(txQ.size() + rxQ.size() + txValid), 11'h000, "queues left");
    give_verdict();
  end
endmodule : acs_async_char_serial_tb
`default_nettype wire
